// [inc/flash_seq_pkg.sv]
package flash_seq_pkg;

	// ****************************************************
	// bus and array geometry
	// ****************************************************
	localparam int ADDR_W       = 16;
	localparam int ARRAY_AW     = 15;            // 32 kbyte array
	localparam int SECTOR_AW    = 12;            // 4 kbyte sector
	localparam int TIMER_W      = 21;

	// ****************************************************
	// register offsets and command addresses
	// ****************************************************
	localparam logic [15:0] CTRL_ADDR    = 16'h0FD0;   // flash_control_primary
	localparam logic [15:0] COMMIT_ADDR  = 16'h0FD1;   // flash_commit_register
	localparam logic [11:0] UNLOCK_A     = 12'h0555;
	localparam logic [11:0] UNLOCK_B     = 12'h0AAA;
	localparam logic [15:0] ID_VENDOR_A  = 16'hF000;
	localparam logic [15:0] ID_ARRAY_A   = 16'hF001;
	localparam logic [15:0] ID_SECURE_A  = 16'hFF7F;

	// ****************************************************
	// data codes
	// ****************************************************
	localparam logic [7:0] CODE_UNLOCK1  = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
	localparam logic [7:0] CODE_PROGRAM  = 8'hA0;
	localparam logic [7:0] CODE_ERASE    = 8'h80;
	localparam logic [7:0] CODE_SECTOR   = 8'h30;
	localparam logic [7:0] CODE_CHIP     = 8'h10;
	localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
	localparam logic [7:0] CODE_ID_EXIT  = 8'hF0;
	localparam logic [7:0] CODE_SECURE   = 8'hA5;
	localparam logic [7:0] CODE_SEC_DATA = 8'h00;
	localparam logic [7:0] COMMIT_KEY    = 8'hD5;
	localparam logic [7:0] ERASED_BYTE   = 8'hFF;
	localparam logic [7:0] SEC_OFF_BYTE  = 8'hFF;
	localparam logic [7:0] SEC_ON_BYTE   = 8'h00;
	localparam logic [7:0] BLOCKED_BYTE  = 8'h00;
	localparam logic [2:0] MODE_ENABLE   = 3'b101;
	localparam logic [2:0] MODE_DISABLE  = 3'b010;
	localparam int         TOGGLE_BIT    = 6;

	// ****************************************************
	// field positions and reset values
	// ****************************************************
	localparam int COMMIT_BUSY_BIT  = 0;
	localparam int COMMIT_SECURE_BIT = 1;
	localparam int COMMIT_ID_BIT    = 2;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_HZ         = 40_000_000;
	localparam int PROG_TIME_US   = 40;
	localparam int SECURE_TIME_US = 40;
	localparam int ERASE_TIME_MS  = 30;
	localparam int PROG_CYCLES    = PROG_TIME_US * (CLK_HZ / 1_000_000);
	localparam int SECURE_CYCLES  = SECURE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int ERASE_CYCLES   = ERASE_TIME_MS * (CLK_HZ / 1_000);

	// ****************************************************
	// types
	// ****************************************************
	typedef struct packed {
		logic [2:0] cmd_mode;     // command_mode_field
		logic       spare4;
		logic [1:0] area;         // target area select
		logic       spare1;
		logic       map_sel;      // array_mapping_select
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{cmd_mode: MODE_DISABLE, default: 1'b0};

	typedef enum logic [2:0] {
		OP_NONE, OP_PROGRAM, OP_SECTOR, OP_CHIP, OP_SECURE
	} op_t;

	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_AA, SEQ_55, SEQ_80, SEQ_80AA, SEQ_8055, SEQ_PROG, SEQ_SEC
	} seq_t;

endpackage

// [rtl/op_timer.sv]
`timescale 1ns/1ps

module op_timer
	import flash_seq_pkg::*;
(
	// clock and reset
	input  wire logic               clock_i,
	input  wire logic               rst_i,
	// control
	input  wire logic               load_i,
	input  wire logic [TIMER_W-1:0] count_i,
	// status
	output logic                    running_o
);

	logic [TIMER_W-1:0] remain;   // cycles left

	// counts down once per cycle after a load
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			remain <= '0;
		end else if (load_i) begin
			remain <= count_i;
		end else if (remain != '0) begin
			remain <= remain - 1'b1;
		end
	end

	// flop so the busy view never glitches
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			running_o <= 1'b0;
		end else begin
			running_o <= load_i || (remain > 1);
		end
	end

endmodule

// [rtl/flash_command_sequencer.sv]
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - id mode maps vendor, array, security bytes
// - security byte all ones when unprotected
// - exit command returns to array reads
// - protected parallel mode blocks reads, byte program and sector erase
// - protected serial mode refuses rewrite, loader
// - only chip erase clears protection
// - protection setting busy for 40 us
// - no new sequence during protection setting
// - bit six flips each read while busy
// - first read after command shows one
// - disabled command mode stops toggling
// - slow mode byte write shows no toggle
// - fetches blocked while busy; flash reads return the array byte with the toggle bit
// - byte program, sector erase, chip erase
// - one-cycle reads, multi-write command sequences
// - enable pattern then commit key applies
// - disable pattern then commit key applies
// - unlock AA then 55, then command code
// - upper address nibble 8 to F accepted
// - erased bytes read as all ones

module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int ERASE_WAIT = ERASE_CYCLES     // shorten for simulation
)(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// cpu byte bus
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [7:0]        wr_data_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [7:0]             rd_data_o,
	// operating mode pins and clock mode
	input  wire logic              parallel_mode_i,
	input  wire logic              serial_mode_i,
	input  wire logic              slow_mode_i,
	// status
	output logic                   fetch_block_o,
	output logic                   id_mode_o,
	output logic                   secure_o,
	output logic                   rewrite_allow_o,
	output logic                   loader_allow_o
);

	// ****************************************************
	// state
	// ****************************************************
	logic [7:0]          mem [0:(1<<ARRAY_AW)-1];  // flash array
	ctrl_t               ctrl_shadow;              // written, not yet committed
	ctrl_t               ctrl_live;                // committed settings
	seq_t                seq;                      // unlock sequence position
	op_t                 op;                       // running operation
	logic                id_mode;                  // product id view
	logic                secure;                   // protection flag
	logic                toggle;                   // next bit six value
	logic                toggle_on;                // op shows toggling
	logic [2:0]          par_sync;                 // parallel pin synchroniser
	logic [2:0]          ser_sync;                 // serial pin synchroniser
	logic                par_mode;                 // filtered parallel mode
	logic                ser_mode;                 // filtered serial mode
	logic [ARRAY_AW-1:0] walk;                     // erase address walker
	logic [ARRAY_AW-1:0] walk_end;                 // last byte to erase
	logic                walking;                  // erase walk active
	logic                timer_run;                // op time not yet over
	logic                timer_load;
	logic [TIMER_W-1:0]  timer_count;
	logic                busy;                     // any operation running
	logic                cmd_ok;                   // commands accepted now
	logic                flash_wr;
	logic                start;                    // an operation begins
	op_t                 next_op;

	// ****************************************************
	// decode helpers
	// ****************************************************
	// flash area is 0x8000 and up, so any upper nibble 8..F is accepted
	function automatic logic in_flash(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1];
	endfunction

	function automatic logic at_cmd(input logic [ADDR_W-1:0] a, input logic [11:0] low);
		return in_flash(a) && (a[11:0] == low);
	endfunction

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	// mode pins are asynchronous: three stages, change taken when last two agree
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			par_sync <= 3'b000;
			ser_sync <= 3'b000;
		end else begin
			par_sync <= {par_sync[1:0], parallel_mode_i};
			ser_sync <= {ser_sync[1:0], serial_mode_i};
		end
	end

	// filtered levels
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			par_mode <= 1'b0;
			ser_mode <= 1'b0;
		end else begin
			if (par_sync[1] == par_sync[2]) begin
				par_mode <= par_sync[2];
			end
			if (ser_sync[1] == ser_sync[2]) begin
				ser_mode <= ser_sync[2];
			end
		end
	end

	// ****************************************************
	// control registers
	// ****************************************************
	// settings only take effect after the commit key, so a stray write to
	// the control register alone cannot enable programming
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_shadow <= CTRL_RESET;
			ctrl_live   <= CTRL_RESET;
		end else if (wr_i) begin
			if (addr_i == CTRL_ADDR) begin
				ctrl_shadow <= ctrl_t'(wr_data_i);
			end else if (addr_i == COMMIT_ADDR && wr_data_i == COMMIT_KEY) begin
				ctrl_live <= ctrl_shadow;
			end
		end
	end

	// ****************************************************
	// command sequence decode
	// ****************************************************
	assign busy     = timer_run || walking;
	assign flash_wr = wr_i && in_flash(addr_i);
	// protected parallel mode refuses program and sector erase; chip erase stays open to clear it
	assign cmd_ok   = !busy && (ctrl_live.cmd_mode == MODE_ENABLE);

	// next operation from the current write
	always_comb begin
		next_op = OP_NONE;
		if (flash_wr && cmd_ok) begin
			case (seq)
				SEQ_PROG: begin
					if (!(par_mode && secure)) begin
						next_op = OP_PROGRAM;
					end
				end
				SEQ_SEC: begin
					if (addr_i == ID_SECURE_A && wr_data_i == CODE_SEC_DATA) begin
						next_op = OP_SECURE;
					end
				end
				SEQ_8055: begin
					if (wr_data_i == CODE_SECTOR && !(par_mode && secure)) begin
						next_op = OP_SECTOR;
					end else if (wr_data_i == CODE_CHIP && at_cmd(addr_i, UNLOCK_A)) begin
						next_op = OP_CHIP;
					end
				end
				default: begin
					next_op = OP_NONE;
				end
			endcase
		end
	end

	assign start = (next_op != OP_NONE);

	// unlock state machine; any unexpected write falls back to idle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			seq <= SEQ_IDLE;
		end else if (flash_wr) begin
			if (!cmd_ok) begin
				seq <= SEQ_IDLE;
			end else begin
				case (seq)
					SEQ_IDLE: begin
						seq <= (at_cmd(addr_i, UNLOCK_A) && wr_data_i == CODE_UNLOCK1)
							? SEQ_AA : SEQ_IDLE;
					end
					SEQ_AA: begin
						seq <= (at_cmd(addr_i, UNLOCK_B) && wr_data_i == CODE_UNLOCK2)
							? SEQ_55 : SEQ_IDLE;
					end
					SEQ_55: begin
						if (!at_cmd(addr_i, UNLOCK_A)) begin
							seq <= SEQ_IDLE;
						end else if (wr_data_i == CODE_PROGRAM) begin
							seq <= SEQ_PROG;
						end else if (wr_data_i == CODE_ERASE) begin
							seq <= SEQ_80;
						end else if (wr_data_i == CODE_SECURE) begin
							seq <= SEQ_SEC;
						end else begin
							seq <= SEQ_IDLE;
						end
					end
					SEQ_80: begin
						seq <= (at_cmd(addr_i, UNLOCK_A) && wr_data_i == CODE_UNLOCK1)
							? SEQ_80AA : SEQ_IDLE;
					end
					SEQ_80AA: begin
						seq <= (at_cmd(addr_i, UNLOCK_B) && wr_data_i == CODE_UNLOCK2)
							? SEQ_8055 : SEQ_IDLE;
					end
					default: begin
						seq <= SEQ_IDLE;  // fourth or sixth write ends it
					end
				endcase
			end
		end
	end

	// ****************************************************
	// product id mode
	// ****************************************************
	// entry needs the unlock; exit is one write of F0 anywhere in flash
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			id_mode <= 1'b0;
		end else if (flash_wr && wr_data_i == CODE_ID_EXIT) begin
			id_mode <= 1'b0;
		end else if (flash_wr && cmd_ok && seq == SEQ_55 && at_cmd(addr_i, UNLOCK_A)
				&& wr_data_i == CODE_ID_ENTRY) begin
			id_mode <= 1'b1;
		end
	end

	// ****************************************************
	// operation engine
	// ****************************************************
	// slow clock: the byte is written before the next read can come
	always_comb begin
		timer_load  = start;
		timer_count = TIMER_W'(PROG_CYCLES);
		case (next_op)
			OP_PROGRAM: begin
				timer_count = slow_mode_i ? TIMER_W'(1) : TIMER_W'(PROG_CYCLES);
			end
			OP_SECURE: begin
				timer_count = TIMER_W'(SECURE_CYCLES);
			end
			OP_SECTOR,
			OP_CHIP: begin
				timer_count = TIMER_W'(ERASE_WAIT);
			end
			default: begin
				timer_count = TIMER_W'(PROG_CYCLES);
			end
		endcase
	end

	op_timer u_timer (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.load_i    (timer_load),
		.count_i   (timer_count),
		.running_o (timer_run)
	);

	// operation kind, held until done, settles protection at the end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			op <= OP_NONE;
		end else if (start) begin
			op <= next_op;
		end else if (!busy) begin
			op <= OP_NONE;
		end
	end

	// protection flag: set by the security program, cleared only by chip erase
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			secure <= 1'b0;
		end else if (op == OP_SECURE && !busy) begin
			secure <= 1'b1;
		end else if (op == OP_CHIP && !busy) begin
			secure <= 1'b0;
		end
	end

	// erase walker clears one byte per cycle over the chosen range
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			walking  <= 1'b0;
			walk     <= '0;
			walk_end <= '0;
		end else if (next_op == OP_SECTOR) begin
			walking  <= 1'b1;
			walk     <= {addr_i[ARRAY_AW-1:SECTOR_AW], {SECTOR_AW{1'b0}}};
			walk_end <= {addr_i[ARRAY_AW-1:SECTOR_AW], {SECTOR_AW{1'b1}}};
		end else if (next_op == OP_CHIP) begin
			walking  <= 1'b1;
			walk     <= '0;
			walk_end <= '1;
		end else if (walking) begin
			walking <= (walk != walk_end);
			walk    <= walk + 1'b1;
		end
	end

	// array writes: the program byte at start, erase bytes while walking
	always_ff @(posedge clock_i) begin
		if (next_op == OP_PROGRAM) begin
			mem[addr_i[ARRAY_AW-1:0]] <= wr_data_i;
		end else if (walking) begin
			mem[walk] <= ERASED_BYTE;
		end
	end

	// ****************************************************
	// toggle bit
	// ****************************************************
	// first read after a command shows one, each later read flips it
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			toggle    <= 1'b0;
			toggle_on <= 1'b0;
		end else if (start) begin
			toggle    <= 1'b1;
			toggle_on <= !(next_op == OP_PROGRAM && slow_mode_i);
		end else if (rd_i && in_flash(addr_i) && busy) begin
			toggle <= !toggle;
		end
	end

	// ****************************************************
	// read port
	// ****************************************************
	// data stand one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == CTRL_ADDR) begin
				rd_data_o <= ctrl_shadow;
			end else if (addr_i == COMMIT_ADDR) begin
				rd_data_o <= 8'h00;
				rd_data_o[COMMIT_BUSY_BIT]   <= busy;
				rd_data_o[COMMIT_SECURE_BIT] <= secure;
				rd_data_o[COMMIT_ID_BIT]     <= id_mode;
			end else if (!in_flash(addr_i)) begin
				rd_data_o <= 8'h00;
			end else if (par_mode && secure) begin
				rd_data_o <= BLOCKED_BYTE;
			end else if (busy) begin
				// only status polling answers while busy
				rd_data_o <= mem[addr_i[ARRAY_AW-1:0]];
				if (toggle_on && ctrl_live.cmd_mode != MODE_DISABLE) begin
					rd_data_o[TOGGLE_BIT] <= toggle;
				end
			end else if (id_mode && addr_i == ID_VENDOR_A) begin
				rd_data_o <= 8'h3C;  // arbitrary vendor code
			end else if (id_mode && addr_i == ID_ARRAY_A) begin
				rd_data_o <= 8'h5A;  // arbitrary array code
			end else if (id_mode && addr_i == ID_SECURE_A) begin
				rd_data_o <= secure ? SEC_ON_BYTE : SEC_OFF_BYTE;
			end else begin
				rd_data_o <= mem[addr_i[ARRAY_AW-1:0]];
			end
		end
	end

	// ****************************************************
	// status outputs
	// ****************************************************
	// registered copies so every output leaves a flop
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fetch_block_o   <= 1'b0;
			id_mode_o       <= 1'b0;
			secure_o        <= 1'b0;
			rewrite_allow_o <= 1'b0;
			loader_allow_o  <= 1'b0;
		end else begin
			fetch_block_o   <= busy || start;
			id_mode_o       <= id_mode;
			secure_o        <= secure;
			rewrite_allow_o <= !(ser_mode && secure);
			loader_allow_o  <= !(ser_mode && secure);
		end
	end

endmodule

// [dv/flash_seq_chk.sv]
`timescale 1ns/1ps

module flash_seq_chk
	import flash_seq_pkg::*;
#(
	parameter int ERASE_WAIT = 1
)(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// cpu byte bus
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [7:0]        wr_data_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic [7:0]        rd_data_o,
	input  wire logic              slow_mode_i,
	// status
	input  wire logic              fetch_block_o,
	input  wire logic              id_mode_o,
	input  wire logic              secure_o,
	input  wire logic              rewrite_allow_o,
	input  wire logic              loader_allow_o
);
	// ****************************************************
	// helper state
	// ****************************************************
	logic [15:0] busy_cnt;   // cycles of the running operation
	logic        fb_q;       // busy one cycle ago
	logic        rd_q;       // a flash read was taken
	logic        rd_busy;    // that read found an operation running
	logic        first;      // next busy read is the first of this operation
	logic        last6;      // toggle bit of the previous busy read

	// busy view lags the engine by one edge, so judge the read against the
	// busy value that stands after its own edge
	assign rd_busy = rd_q && fetch_block_o;

	// track busy reads so each answer can be tied to the one before
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt <= '0;
			fb_q     <= 1'b0;
			rd_q     <= 1'b0;
			first    <= 1'b0;
			last6    <= 1'b0;
		end else begin
			busy_cnt <= fetch_block_o ? busy_cnt + 16'h0001 : '0;
			fb_q     <= fetch_block_o;
			rd_q     <= rd_i && addr_i[15] && !slow_mode_i;
			// a new operation restarts the toggle sequence
			if (fetch_block_o && !fb_q) begin
				first <= 1'b1;
			end else if (rd_busy) begin
				first <= 1'b0;
			end
			if (rd_busy) begin
				last6 <= rd_data_o[TOGGLE_BIT];
			end
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// ****************************************************
	// properties
	// ****************************************************
	property p_rd_hold;
		!rd_i |=> $stable(rd_data_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

	property p_allow_pair;
		rewrite_allow_o == loader_allow_o;
	endproperty
	a_allow_pair: assert property (p_allow_pair) else $error("rewrite and loader differ");

	property p_allow_sec;
		$fell(rewrite_allow_o) |-> secure_o;
	endproperty
	a_allow_sec: assert property (p_allow_sec) else $error("rewrite refused unprotected");

	property p_sec_clear;
		$fell(secure_o) |-> $past(fetch_block_o, 2);
	endproperty
	a_sec_clear: assert property (p_sec_clear) else $error("protection cleared idle");

	property p_sec_set;
		$rose(secure_o) |-> (busy_cnt != 0 || $past(busy_cnt) != 0)
			&& busy_cnt <= SECURE_CYCLES + 1 && $past(busy_cnt) <= SECURE_CYCLES + 1;
	endproperty
	a_sec_set: assert property (p_sec_set) else $error("protection set time wrong");

	property p_busy_start;
		$rose(fetch_block_o) |-> $past(wr_i) || $past(wr_i, 2);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy without a write");

	property p_id_exit;
		wr_i && addr_i[15] && wr_data_i == CODE_ID_EXIT && !fetch_block_o |-> ##[1:2] !id_mode_o;
	endproperty
	a_id_exit: assert property (p_id_exit) else $error("id mode kept after exit");

	property p_id_hold;
		id_mode_o && !wr_i && !$past(wr_i) |=> id_mode_o;
	endproperty
	a_id_hold: assert property (p_id_hold) else $error("id mode lost on reads");

	property p_toggle;
		rd_busy |-> rd_data_o[TOGGLE_BIT] == (first ? 1'b1 : !last6);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle bit wrong while busy");

	c_id: cover property ($rose(id_mode_o));
	c_sec: cover property ($rose(secure_o));
	c_done: cover property ($fell(fetch_block_o));
endmodule

bind flash_command_sequencer flash_seq_chk #(.ERASE_WAIT(ERASE_WAIT)) chk (
	.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .slow_mode_i(slow_mode_i),
	.fetch_block_o(fetch_block_o), .id_mode_o(id_mode_o), .secure_o(secure_o),
	.rewrite_allow_o(rewrite_allow_o), .loader_allow_o(loader_allow_o));

// [dv/cpu_bus_model.sv]
`timescale 1ns/1ps

// cpu side of the byte bus; byte transfers only, never 16-bit
module cpu_bus_model
	import flash_seq_pkg::*;
(
	// clock
	input  wire logic              clock_i,
	// bus towards the sequencer
	output logic [ADDR_W-1:0]      addr_o,
	output logic [7:0]             wr_data_o,
	output logic                   wr_o,
	output logic                   rd_o,
	input  wire logic [7:0]        rd_data_i
);
	// idle bus at time zero
	initial begin
		addr_o = '0;
		wr_data_o = '0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// one write; released lines flip so stale values never look valid
	task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o    <= a;
		wr_data_o <= d;
		wr_o      <= 1'b1;
		@(posedge clock_i);
		wr_o      <= 1'b0;
		addr_o    <= ~a;
		wr_data_o <= ~d;
		@(negedge clock_i);
	endtask

	// one read is one transfer; data taken in the cycle after the strobe
	task automatic rd_b(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clock_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		@(negedge clock_i);
		d = rd_data_i;
	endtask

	// unlock pair; any upper nibble 8..F is allowed
	task automatic unlock(input logic [3:0] nib);
		wr_b({nib, UNLOCK_A}, CODE_UNLOCK1);
		wr_b({nib, UNLOCK_B}, CODE_UNLOCK2);
	endtask
endmodule

// [dv/flash_command_sequencer_tb.sv]
`timescale 1ns/1ps

module flash_command_sequencer_tb
	import flash_seq_pkg::*;
;
	localparam logic [7:0] VENDOR = 8'h3C;   // arbitrary code
	localparam logic [7:0] ARRAY  = 8'h5A;   // arbitrary code

	logic              clock_i;
	logic              rst_i;
	logic              par_i;      // parallel programmer pin
	logic              ser_i;      // serial programming pin
	logic              slow_i;     // low-speed clock mode
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              wr;
	logic              rd;
	logic [7:0]        rdata;
	logic              busy;
	logic              id_mode;
	logic              secure;
	logic              rw_ok;
	logic              ld_ok;
	logic [7:0]        d;
	logic [7:0]        e;
	int                err_count = 0;
	int                n_tests = 0;

	cpu_bus_model cpu (.clock_i(clock_i), .addr_o(addr), .wr_data_o(wdata), .wr_o(wr),
		.rd_o(rd), .rd_data_i(rdata));

	// short erase wait keeps the run small; the walk still covers every byte
	flash_command_sequencer #(.ERASE_WAIT(5000)) dut (.clock_i(clock_i), .rst_i(rst_i),
		.addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata),
		.parallel_mode_i(par_i), .serial_mode_i(ser_i), .slow_mode_i(slow_i),
		.fetch_block_o(busy), .id_mode_o(id_mode), .secure_o(secure),
		.rewrite_allow_o(rw_ok), .loader_allow_o(ld_ok));

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// mode pattern then commit key
	task automatic set_mode(input logic [2:0] m);
		cpu.wr_b(CTRL_ADDR, {m, 5'h00});
		cpu.wr_b(COMMIT_ADDR, COMMIT_KEY);
	endtask

	// poll until two reads agree; the first two reads show the toggle
	task automatic poll(input logic [15:0] a);
		logic [7:0] d0;
		logic [7:0] d1;
		int         i;
		cpu.rd_b(a, d0);
		chk(d0 & 8'h40, 8'h40);
		cpu.rd_b(a, d1);
		chk((d0 ^ d1) & 8'h40, 8'h40);
		for (i = 0; i < 20000; i++) begin
			cpu.rd_b(a, d0);
			cpu.rd_b(a, d1);
			if (d0 === d1) break;
		end
		if (i == 20000) begin
			err_count++;
			results();
		end
		chk({7'h00, busy}, 8'h00);
	endtask

	// slow pins pass a filter, so give them time
	task automatic pins(input logic p, input logic s);
		@(posedge clock_i);
		par_i <= p;
		ser_i <= s;
		repeat (8) @(negedge clock_i);
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_erase;
		cpu.unlock(4'h8);
		cpu.wr_b(16'h8555, CODE_ERASE);
		cpu.unlock(4'hF);
		cpu.wr_b(16'hF000, CODE_SECTOR);
		poll(16'hF000);
		cpu.rd_b(16'hFFFF, d);
		chk(d, ERASED_BYTE);
	endtask

	task automatic t_prog(input logic [15:0] a, input logic [7:0] v);
		cpu.unlock(4'hF);
		cpu.wr_b({4'hF, UNLOCK_A}, CODE_PROGRAM);
		cpu.wr_b(a, v);
	endtask

	task automatic t_id(input logic [7:0] sec);
		cpu.unlock(4'hF);
		cpu.wr_b({4'hF, UNLOCK_A}, CODE_ID_ENTRY);
		@(negedge clock_i);
		chk({7'h00, id_mode}, 8'h01);
		foreach (e[i]) begin
			cpu.rd_b(i[0] ? ID_ARRAY_A : ID_VENDOR_A, d);
			chk(d, i[0] ? ARRAY : VENDOR);
		end
		cpu.rd_b(ID_SECURE_A, d);
		chk(d, sec);
		cpu.wr_b(16'hF000, CODE_ID_EXIT);
		@(negedge clock_i);
		chk({7'h00, id_mode}, 8'h00);
		cpu.rd_b(ID_VENDOR_A, d);
		chk(d, ERASED_BYTE);
	endtask

	task automatic t_secure;
		cpu.unlock(4'hF);
		cpu.wr_b({4'hF, UNLOCK_A}, CODE_SECURE);
		cpu.wr_b(ID_SECURE_A, CODE_SEC_DATA);
		poll(16'hF123);
		@(negedge clock_i);
		chk({7'h00, secure}, 8'h01);
		t_id(SEC_ON_BYTE);
		pins(1'b0, 1'b1);
		chk({6'h00, rw_ok, ld_ok}, 8'h00);
		pins(1'b1, 1'b0);
		chk({6'h00, rw_ok, ld_ok}, 8'h03);
		cpu.rd_b(16'hF123, d);
		chk(d, BLOCKED_BYTE);
		t_prog(16'hF300, 8'h55);
		@(negedge clock_i);
		chk({7'h00, busy}, 8'h00);
		pins(1'b0, 1'b0);
	endtask

	task automatic t_chip;
		cpu.unlock(4'hF);
		cpu.wr_b({4'hF, UNLOCK_A}, CODE_ERASE);
		cpu.unlock(4'hF);
		cpu.wr_b({4'hF, UNLOCK_A}, CODE_CHIP);
		poll(16'hF123);
		@(negedge clock_i);
		chk({7'h00, secure}, 8'h00);
		cpu.rd_b(16'hF123, d);
		chk(d, ERASED_BYTE);
	endtask

	// ****************************************************
	// clock and main sequence
	// ****************************************************
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	// no reset is applied while an operation runs
	initial begin
		rst_i = 1'b1;
		par_i = 1'b0;
		ser_i = 1'b0;
		slow_i = 1'b0;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		set_mode(MODE_ENABLE);
		t_erase();
		t_prog(16'hF123, 8'h3F);
		poll(16'hF123);
		cpu.rd_b(16'hF123, d);
		chk(d, 8'h3F);
		t_id(SEC_OFF_BYTE);
		// slow clock: program is over before the next read
		@(posedge clock_i);
		slow_i <= 1'b1;
		t_prog(16'hF200, 8'h12);
		repeat (2) @(negedge clock_i);
		cpu.rd_b(16'hF200, d);
		chk(d, 8'h12);
		cpu.rd_b(16'hF200, d);
		chk(d, 8'h12);
		@(posedge clock_i);
		slow_i <= 1'b0;
		t_secure();
		t_chip();
		// disabled mode: the sequence is ignored
		set_mode(MODE_DISABLE);
		t_prog(16'hF400, 8'h00);
		@(negedge clock_i);
		chk({7'h00, busy}, 8'h00);
		cpu.rd_b(16'hF400, d);
		chk(d, ERASED_BYTE);
		cpu.rd_b(16'h1234, d);
		chk(d, 8'h00);
		results();
	end
endmodule
